// file: common/dxd_pkg.sv
// shared constants and types for the signal-processing extension opcode decoder
package dxd_pkg;

   // ***************************************************
   // opcode field positions
   // ***************************************************
   localparam int MAJ_ROW_MSB = 31;
   localparam int MAJ_ROW_LSB = 29;
   localparam int MAJ_COL_MSB = 28;
   localparam int MAJ_COL_LSB = 26;
   localparam int MIN_ROW_MSB = 2;
   localparam int MIN_ROW_LSB = 0;
   localparam int MIN_COL_MSB = 5;
   localparam int MIN_COL_LSB = 3;
   localparam int MIN_SUB_MSB = 9;
   localparam int MIN_SUB_LSB = 6;
   localparam int AXF_MSB = 15;
   localparam int AXF_LSB = 6;
   localparam int COP_MSB = 15;
   localparam int COP_LSB = 14;

   // ***************************************************
   // major table entries
   // ***************************************************
   localparam logic [5:0] MAJ_POOL_A = 6'h00;       // shared_major_pool_a, row 0 col 0
   localparam logic [5:0] MAJ_HIGHER_ISA = 6'h32;   // row 6 col 2
   localparam logic [2:0] MAJ_RSVD_ROW_MAX = 3'h1;  // rows 0 and 1 ...
   localparam logic [2:0] MAJ_RSVD_COL_MIN = 3'h4;  // ... columns 4 to 7 reserved

   // ***************************************************
   // secondary table classes and decoder results
   // ***************************************************
   typedef enum logic [3:0] {
      MC_BASE = 4'h0, MC_RSVD = 4'h1, MC_DSP = 4'h2, MC_DSP_R2 = 4'h3,
      MC_FIELD = 4'h4, MC_DEBUG = 4'h5, MC_ASE = 4'h6, MC_VENDOR = 4'h7,
      MC_COP = 4'h8
   } dxd_mcls_t;

   typedef enum logic [2:0] {
      DC_NONE = 3'h0, DC_BASE = 3'h1, DC_DSP = 3'h2, DC_DEBUG = 3'h3,
      DC_ASE = 3'h4, DC_VENDOR = 3'h5
   } dxd_dcls_t;

   typedef enum logic [1:0] {
      EC_NONE = 2'h0, EC_RSVD_INSTR = 2'h1, EC_COP_UNUSABLE = 2'h2
   } dxd_cause_t;

   localparam logic [0:0] TBL_PRIMARY = 1'b0;
   localparam logic [0:0] TBL_AXF = 1'b1;
   localparam logic [5:0] AXF_R2_FIRST = 6'h30;
   localparam logic [5:0] AXF_RSVD_FIRST = 6'h38;

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic dsp_en;         // extension implemented
      logic rel2;           // release 2 implementation
      logic debug_en;       // debug-support codes implemented
      logic ase_en;         // application-specific extension implemented
      logic vendor_en;      // vendor instruction assigned in vendor_special_space_two
      logic [3:0] cop_usable;
   } dxd_cfg_t;

   typedef struct packed {
      logic valid;
      logic [31:0] instr;
   } dxd_fetch_t;

   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      dxd_dcls_t cls;
      logic exc_req;
      dxd_cause_t cause;
      logic [1:0] cop_num;
   } dxd_dec_t;

   localparam dxd_dec_t DEC_RST = '0;
   localparam dxd_mcls_t ROM_RST = MC_BASE;

endpackage

// file: design/dxd_rom.sv
// minor-opcode lookup table with registered read data
`timescale 1ns/1ps
module dxd_rom
   import dxd_pkg::*;
#(
   parameter logic [0:0] TABLE = TBL_PRIMARY
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [9:0] addr,
   output dxd_mcls_t rd_data_q
);

   // ***************************************************
   // table contents
   // ***************************************************
   // kept as a function so the table is a constant the tool folds into a rom
   function automatic dxd_mcls_t lookup(input logic [9:0] a);
      logic [2:0] r;
      logic [2:0] c;
      logic [3:0] s;
      dxd_mcls_t v;
      r = a[2:0];
      c = a[5:3];
      s = a[9:6];
      v = MC_RSVD;
      if (TABLE == TBL_AXF)
      begin
         if (a[5:0] < AXF_R2_FIRST) v = MC_DSP;
         else if (a[5:0] < AXF_RSVD_FIRST) v = MC_DSP_R2;
      end
      else
      begin
         case (r)
            3'h0, 3'h1, 3'h2, 3'h3: v = MC_BASE;
            3'h4: v = (c == 3'h7) ? MC_FIELD : MC_RSVD;
            3'h5:
            begin
               case (c)
                  3'h0: v = MC_DSP;
                  3'h1: v = (s == 4'h1 || s == 4'h2) ? MC_DSP_R2 : MC_DSP;
                  3'h2: v = (s > 4'hb) ? MC_RSVD : (s >= 4'h8) ? MC_DSP_R2 : MC_DSP;
                  3'h3: v = (s == 4'h0) ? MC_DSP : MC_RSVD;
                  3'h4: v = (s inside {4'h0, 4'h1, 4'h5, 4'h6, 4'h8}) ? MC_DSP : MC_RSVD;
                  3'h5: v = (s <= 4'h8) ? MC_DSP : MC_RSVD;
                  3'h6: v = (s == 4'hb) ? MC_DSP : MC_RSVD;
                  default: v = (s == 4'h0) ? MC_DSP : MC_RSVD;
               endcase
            end
            3'h6: v = (c == 3'h0) ? MC_ASE : MC_RSVD;
            default:
            begin
               case (c)
                  3'h0: v = MC_DEBUG;
                  3'h1: v = MC_VENDOR;
                  3'h2: v = MC_COP;
                  default: v = MC_RSVD;
               endcase
            end
         endcase
      end
      return v;
   endfunction

   // registered read, one cycle after the address
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn) rd_data_q <= ROM_RST;
      else rd_data_q <= lookup(addr);
   end

endmodule // dxd_rom

// file: design/dxd_decoder.sv
// major and minor opcode decoder for the signal-processing extension
`timescale 1ns/1ps
// Function
// - reserved codes raise reserved-instruction exception
// - field-class codes decoded through a further table
// - higher-level architecture encodings are rejected
// - unassigned licensee codes: reserved or coprocessor-unusable
// - optional debug codes decode, else reserved exception
// - extension codes decode only when extension present
// - release 2 codes trap on release 1
// - major row bits 31..29, column 28..26
// - extension lives in pool row 0 column 0
module dxd_decoder
   import dxd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input dxd_fetch_t fetch,
   input dxd_cfg_t cfg,
   output dxd_dec_t dec_q
);

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      dxd_cfg_t cfg;
      logic pool;
      logic higher;
      logic rsvd;
      dxd_dec_t dec;
   } dxd_state_t;

   dxd_state_t st_q;
   dxd_state_t st_d;
   dxd_mcls_t prim_cls;
   dxd_mcls_t axf_cls;
   logic [2:0] maj_row;
   logic [2:0] maj_col;
   logic [5:0] maj_op;

   // row and column of the major table
   assign maj_row = fetch.instr[MAJ_ROW_MSB:MAJ_ROW_LSB];
   assign maj_col = fetch.instr[MAJ_COL_MSB:MAJ_COL_LSB];
   assign maj_op = {maj_row, maj_col};

   // both minor tables are read in parallel so a field class costs no extra cycle
   dxd_rom #(.TABLE(TBL_PRIMARY)) u_prim (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .addr(fetch.instr[MIN_SUB_MSB:0]),
      .rd_data_q(prim_cls)
   );

   dxd_rom #(.TABLE(TBL_AXF)) u_axf (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .addr(fetch.instr[AXF_MSB:AXF_LSB]),
      .rd_data_q(axf_cls)
   );

   // ***************************************************
   // class resolution
   // ***************************************************
   function automatic dxd_dec_t resolve(input dxd_mcls_t c, input dxd_state_t s);
      dxd_dec_t r;
      logic [1:0] cop;
      r = DEC_RST;
      cop = s.instr[COP_MSB:COP_LSB];
      r.valid = 1'b1;
      r.instr = s.instr;
      r.cls = DC_NONE;
      r.cause = EC_RSVD_INSTR;
      case (c)
         MC_BASE: r.cause = EC_NONE;
         MC_DSP: if (s.cfg.dsp_en) r.cause = EC_NONE;
         MC_DSP_R2: if (s.cfg.dsp_en && s.cfg.rel2) r.cause = EC_NONE;
         MC_DEBUG: if (s.cfg.debug_en) r.cause = EC_NONE;
         MC_ASE: if (s.cfg.ase_en) r.cause = EC_NONE;
         MC_VENDOR: if (s.cfg.vendor_en) r.cause = EC_NONE;
         MC_COP:
         begin
            // nothing assigned here: usable coprocessor traps reserved, else unusable
            r.cop_num = cop;
            if (!s.cfg.cop_usable[cop]) r.cause = EC_COP_UNUSABLE;
         end
         default: r.cause = EC_RSVD_INSTR;
      endcase
      if (r.cause == EC_NONE)
      begin
         case (c)
            MC_BASE: r.cls = DC_BASE;
            MC_DSP, MC_DSP_R2: r.cls = DC_DSP;
            MC_DEBUG: r.cls = DC_DEBUG;
            MC_ASE: r.cls = DC_ASE;
            MC_VENDOR: r.cls = DC_VENDOR;
            default: r.cls = DC_NONE;
         endcase
      end
      r.exc_req = (r.cause != EC_NONE);
      return r;
   endfunction

   // ***************************************************
   // next state
   // ***************************************************
   // stage one classifies the major opcode while the tables are read;
   // stage two merges both so class and exception leave together
   always_comb
   begin
      st_d = st_q;
      st_d.valid = fetch.valid;
      st_d.instr = fetch.instr;
      st_d.cfg = cfg;
      st_d.pool = (maj_op == MAJ_POOL_A);
      st_d.higher = (maj_op == MAJ_HIGHER_ISA);
      st_d.rsvd = (maj_row <= MAJ_RSVD_ROW_MAX) && (maj_col >= MAJ_RSVD_COL_MIN);
      st_d.dec = DEC_RST;
      if (st_q.valid)
      begin
         if (st_q.higher || st_q.rsvd)
         begin
            st_d.dec = resolve(MC_RSVD, st_q);
         end
         else if (!st_q.pool)
         begin
            st_d.dec = resolve(MC_BASE, st_q);
         end
         else if (prim_cls == MC_FIELD)
         begin
            st_d.dec = resolve(axf_cls, st_q);
         end
         else
         begin
            st_d.dec = resolve(prim_cls, st_q);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn) st_q <= '0;
      else st_q <= st_d;
   end

   assign dec_q = st_q.dec;

   // ***************************************************
   // checks
   // ***************************************************
   logic [2:0] min_row;
   logic [2:0] min_col;
   logic [3:0] min_sub;
   assign min_row = fetch.instr[MIN_ROW_MSB:MIN_ROW_LSB];
   assign min_col = fetch.instr[MIN_COL_MSB:MIN_COL_LSB];
   assign min_sub = fetch.instr[MIN_SUB_MSB:MIN_SUB_LSB];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   property p_latency;
      fetch.valid |-> ##2 dec_q.valid && dec_q.instr == $past(fetch.instr, 2);
   endproperty
   a_latency: assert property (p_latency) else $error("decode not aligned");

   property p_single_exc;
      dec_q.valid |-> dec_q.exc_req == (dec_q.cause != EC_NONE)
         && (dec_q.exc_req == (dec_q.cls == DC_NONE));
   endproperty
   a_single_exc: assert property (p_single_exc) else $error("class and cause disagree");

   property p_higher;
      fetch.valid && maj_op == 6'h32 |-> ##2 dec_q.cause == EC_RSVD_INSTR;
   endproperty
   a_higher: assert property (p_higher) else $error("higher level code accepted");

   property p_rsvd_major;
      fetch.valid && maj_row <= 3'h1 && maj_col >= 3'h4 |-> ##2 dec_q.cause == EC_RSVD_INSTR;
   endproperty
   a_rsvd_major: assert property (p_rsvd_major) else $error("reserved major accepted");

   property p_base_pass;
      fetch.valid && maj_op != 6'h00 && maj_op != 6'h32 && !(maj_row <= 3'h1 && maj_col >= 3'h4)
         |-> ##2 dec_q.cls == DC_BASE && !dec_q.exc_req;
   endproperty
   a_base_pass: assert property (p_base_pass) else $error("base major not passed");

   property p_dsp_pool;
      fetch.valid && maj_op == 6'h00 && min_row == 3'h5 && min_col == 3'h0 && cfg.dsp_en
         |-> ##2 dec_q.cls == DC_DSP;
   endproperty
   a_dsp_pool: assert property (p_dsp_pool) else $error("pool code not decoded");

   property p_rel1;
      fetch.valid && maj_op == 6'h00 && min_row == 3'h5 && min_col == 3'h2
         && min_sub == 4'h8 && !cfg.rel2 |-> ##2 dec_q.cause == EC_RSVD_INSTR;
   endproperty
   a_rel1: assert property (p_rel1) else $error("release 2 code on release 1");

   property p_ase_off;
      fetch.valid && maj_op == 6'h00 && min_row == 3'h6 && min_col == 3'h0 && !cfg.ase_en
         |-> ##2 dec_q.exc_req;
   endproperty
   a_ase_off: assert property (p_ase_off) else $error("absent extension decoded");

   property p_debug;
      fetch.valid && maj_op == 6'h00 && min_row == 3'h7 && min_col == 3'h0
         |-> ##2 (dec_q.cls == DC_DEBUG) == $past(cfg.debug_en, 2);
   endproperty
   a_debug: assert property (p_debug) else $error("debug code misdecoded");

   property p_cop;
      fetch.valid && maj_op == 6'h00 && min_row == 3'h7 && min_col == 3'h2
         && !cfg.cop_usable[fetch.instr[15:14]] |-> ##2 dec_q.cause == EC_COP_UNUSABLE;
   endproperty
   a_cop: assert property (p_cop) else $error("coprocessor trap missing");

   property p_field;
      fetch.valid && maj_op == 6'h00 && min_row == 3'h4 && min_col == 3'h7
         && fetch.instr[11:6] < 6'h30 && cfg.dsp_en |-> ##2 dec_q.cls == DC_DSP;
   endproperty
   a_field: assert property (p_field) else $error("field class not decoded");

   c_dsp: cover property (dec_q.valid && dec_q.cls == DC_DSP);
   c_rsvd: cover property (dec_q.valid && dec_q.cause == EC_RSVD_INSTR);
   c_cop: cover property (dec_q.valid && dec_q.cause == EC_COP_UNUSABLE);
   c_b2b: cover property (dec_q.valid [*3]);

endmodule // dxd_decoder

// file: verification/dxd_fetch_model.sv
// fetch-stage model that presents instruction words to the decoder
`timescale 1ns/1ps
module dxd_fetch_model
   import dxd_pkg::*;
(
   output dxd_fetch_t fetch
);
   logic [31:0] last_w = 32'h0000_0000;

   initial fetch = '0;

   // present one word; called just after a falling edge, held until the next call
   task automatic issue(input logic [31:0] w);
      begin
         fetch.valid = 1'b1;
         fetch.instr = w; // callers only hand over current codes, no obsolete ones
         last_w = w;
      end
   endtask

   // no word: the bus shows the inverse so a stale word is never mistaken for data
   task automatic idle();
      begin
         fetch.valid = 1'b0;
         fetch.instr = ~last_w;
      end
   endtask
endmodule // dxd_fetch_model

// file: verification/dxd_decoder_test.sv
// self-checking testbench for the extension opcode decoder
`timescale 1ns/1ps
module dxd_decoder_test
   import dxd_pkg::*;
;
   localparam dxd_cfg_t CA = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf};
   localparam dxd_cause_t RI = EC_RSVD_INSTR;
   localparam dxd_cause_t OK = EC_NONE;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   dxd_cfg_t cfg = '0;
   dxd_fetch_t fetch;
   dxd_dec_t dec_q;
   dxd_dec_t exp0 = '0;
   dxd_dec_t exp1;
   dxd_dec_t exp2;
   int failures = 0;
   int cmp_count = 0;

   dxd_fetch_model fm (.fetch(fetch));
   dxd_decoder dut (.sys_clk(sys_clk), .resetn(resetn), .fetch(fetch), .cfg(cfg), .dec_q(dec_q));

   always #2.5 sys_clk = ~sys_clk;

   // *********************************************
   // scoreboard: expectation delayed by the fixed latency of two
   // *********************************************
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         exp1 <= '0;
         exp2 <= '0;
      end
      else
      begin
         exp1 <= exp0;
         exp2 <= exp1;
      end
   end

   // compare every cycle, idle ones too; a trapped word must show no class
   always @(negedge sys_clk)
   begin
      cmp_count++;
      if (dec_q.valid !== exp2.valid || dec_q.instr !== exp2.instr || dec_q.cause !== exp2.cause
          || dec_q.exc_req !== exp2.exc_req || dec_q.cop_num !== exp2.cop_num
          || dec_q.cls !== exp2.cls)
      begin
         failures++;
         $display("[FAIL] %0t decode got %h expected %h", $time, dec_q, exp2);
      end
   end

   // *********************************************
   // drivers and word builders
   // *********************************************
   task automatic put(input logic [31:0] w, input dxd_cfg_t k, input dxd_dcls_t c,
      input dxd_cause_t e, input logic [1:0] cp);
      begin
         @(negedge sys_clk);
         cfg = k;
         fm.issue(w);
         exp0 = '{1'b1, w, c, (e != OK), e, cp};
      end
   endtask

   task automatic drain();
      begin
         repeat (3)
         begin
            @(negedge sys_clk);
            fm.idle();
            exp0 = '0;
         end
      end
   endtask

   function automatic logic [31:0] mk(input logic [2:0] r, input logic [2:0] c,
      input logic [3:0] s);
      mk = {6'h00, 16'h0000, s, c, r};
   endfunction

   function automatic logic [31:0] mkx(input logic [5:0] x);
      mkx = {6'h00, 14'h0000, x, 3'h7, 3'h4};
   endfunction

   // *********************************************
   // scenarios, all back to back
   // *********************************************
   task automatic t_major();
      begin
         put(32'h0c00_0000, CA, DC_BASE, OK, 2'h0);
         put(32'h1000_0000, CA, DC_NONE, RI, 2'h0);
         put(32'h3c00_0000, CA, DC_NONE, RI, 2'h0);
         put(32'h2000_0000, CA, DC_BASE, OK, 2'h0);
         put(32'hc800_0000, CA, DC_NONE, RI, 2'h0);
         put(32'h5800_0000, CA, DC_BASE, OK, 2'h0);
         put(32'hcc00_0000, CA, DC_BASE, OK, 2'h0);
         put(32'hfc00_0000, CA, DC_BASE, OK, 2'h0);
         drain();
      end
   endtask

   task automatic t_pool();
      dxd_cfg_t k;
      begin
         k = CA;
         k.dsp_en = 1'b0;
         put(mk(3'h0, 3'h0, 4'h0), CA, DC_BASE, OK, 2'h0);
         put(mk(3'h3, 3'h7, 4'hf), CA, DC_BASE, OK, 2'h0);
         put(mk(3'h5, 3'h0, 4'h0), CA, DC_DSP, OK, 2'h0);
         put(mk(3'h5, 3'h0, 4'h0), k, DC_NONE, RI, 2'h0);
         put(mk(3'h0, 3'h5, 4'h0), CA, DC_BASE, OK, 2'h0);
         put(mk(3'h5, 3'h3, 4'h1), CA, DC_NONE, RI, 2'h0);
         put(mk(3'h4, 3'h0, 4'h0), CA, DC_NONE, RI, 2'h0);
         drain();
      end
   endtask

   task automatic t_field();
      dxd_cfg_t k;
      begin
         k = CA;
         k.rel2 = 1'b0;
         put(mkx(6'h00), k, DC_DSP, OK, 2'h0);
         put(mkx(6'h2f), k, DC_DSP, OK, 2'h0);
         put(mkx(6'h30), CA, DC_DSP, OK, 2'h0);
         put(mkx(6'h30), k, DC_NONE, RI, 2'h0);
         put(mkx(6'h37), CA, DC_DSP, OK, 2'h0);
         put(mkx(6'h37), k, DC_NONE, RI, 2'h0);
         put(mkx(6'h38), CA, DC_NONE, RI, 2'h0);
         put(mkx(6'h3f), CA, DC_NONE, RI, 2'h0);
         put(mk(3'h5, 3'h1, 4'h1), CA, DC_DSP, OK, 2'h0);
         put(mk(3'h5, 3'h1, 4'h1), k, DC_NONE, RI, 2'h0);
         put(mk(3'h5, 3'h2, 4'h8), k, DC_NONE, RI, 2'h0);
         put(mk(3'h5, 3'h2, 4'hb), CA, DC_DSP, OK, 2'h0);
         put(mk(3'h5, 3'h2, 4'hc), CA, DC_NONE, RI, 2'h0);
         drain();
      end
   endtask

   task automatic t_opt();
      dxd_cfg_t k;
      begin
         k = '0;
         put(mk(3'h7, 3'h0, 4'h0), CA, DC_DEBUG, OK, 2'h0);
         put(mk(3'h7, 3'h0, 4'h0), k, DC_NONE, RI, 2'h0);
         put(mk(3'h6, 3'h0, 4'h0), CA, DC_ASE, OK, 2'h0);
         put(mk(3'h6, 3'h0, 4'h0), k, DC_NONE, RI, 2'h0);
         put(mk(3'h7, 3'h1, 4'h0), CA, DC_VENDOR, OK, 2'h0);
         put(mk(3'h7, 3'h1, 4'h0), k, DC_NONE, RI, 2'h0);
         // each coprocessor alone usable, then alone locked, to catch index slips
         for (int i = 0; i < 4; i++)
         begin
            k = CA;
            k.cop_usable = 4'h1 << i;
            put({16'h0000, 2'(i), 14'h0017}, k, DC_NONE, RI, 2'(i));
            k.cop_usable = ~(4'h1 << i);
            put({16'h0000, 2'(i), 14'h0017}, k, DC_NONE, EC_COP_UNUSABLE, 2'(i));
         end
         drain();
      end
   endtask

   // reset with words in flight: results must vanish, decoding resumes afterwards
   task automatic t_reset();
      begin
         put(mk(3'h5, 3'h0, 4'h0), CA, DC_DSP, OK, 2'h0);
         @(negedge sys_clk);
         #1 resetn = 1'b0;
         fm.idle();
         exp0 = '0;
         repeat (3) @(negedge sys_clk);
         resetn = 1'b1;
         put(32'hc800_0000, CA, DC_NONE, RI, 2'h0);
         drain();
      end
   endtask

   task automatic results();
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   // main sequence
   initial
   begin
      fm.idle();
      repeat (16) @(negedge sys_clk);
      resetn = 1'b1;
      t_major();
      t_pool();
      t_field();
      t_opt();
      t_reset();
      results();
   end

   // watchdog: the whole run needs well under a thousand cycles
   initial
   begin
      #20000;
      failures++;
      results();
   end
endmodule // dxd_decoder_test
